// ---- rtl/ospc_pkg.sv ----
// ospc_pkg: register map, field layout and shared types of the one-shot pulse control block
// assumes a single 40 MHz system clock and an 8-bit register port
package ospc_pkg;

	// ==========================================================
	// register map
	localparam int OSPC_ADDR_W = 3;
	localparam logic [2:0] OSPC_ADDR_CTRL = 3'h0;
	localparam logic [2:0] OSPC_ADDR_PRE_FIRST = 3'h1;
	localparam logic [2:0] OSPC_ADDR_PRE_SECOND = 3'h2;
	localparam logic [2:0] OSPC_ADDR_PRE_NINTH = 3'h3;
	localparam logic [2:0] OSPC_ADDR_WL_PRESET = 3'h4;
	localparam logic [2:0] OSPC_ADDR_STATUS = 3'h5;
	localparam logic [2:0] OSPC_ADDR_CNT_LOW = 3'h6;
	localparam logic [2:0] OSPC_ADDR_CNT_HIGH = 3'h7;

	// ==========================================================
	// field positions and reset values
	localparam int OSPC_NINTH_FIRST_BIT = 0;
	localparam int OSPC_NINTH_SECOND_BIT = 4;
	localparam int OSPC_STAT_ACTIVE_BIT = 0;
	localparam int OSPC_STAT_BLOCK_BIT = 1;
	localparam logic [7:0] OSPC_CTRL_RESET = 8'h00;
	localparam logic [7:0] OSPC_BYTE_ZERO = 8'h00;
	localparam logic [8:0] OSPC_CNT_LAST = 9'h1FF;
	localparam logic [7:0] OSPC_WL_LAST = 8'hFF;

	// ==========================================================
	// timing: width limit timer runs at half the system clock
	localparam int OSPC_WL_DIV_RATIO = 2;
	localparam logic OSPC_WL_DIV_LAST = 1'(OSPC_WL_DIV_RATIO - 1);

	// ==========================================================
	// types
	typedef struct packed {
		logic soft_trigger_bit;
		logic ext_restart_enable;
		logic comparator_stop_enable;
		logic reload_source_select;
		logic [1:0] rsvd;
		logic edge_count_select;
		logic comparator_reload_enable;
	} ospc_ctrl_t;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [OSPC_ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} ospc_bus_req_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SYNC,
		ST_RUN
	} ospc_state_t;

endpackage

// ---- rtl/ospc_top.sv ----
// ospc_top: control of a single-shot 9-bit pulse generator with width limiter
// assumes comparator outputs arrive already debounced but asynchronous to clk,
// and that the non-retrigger interval timer is ordinary logic on clk
//
// How it works
// R1 - a width limit timer starts with the pulse and halts on its overflow or when the pulse stops.
// R2 - width limit overflow ends the pulse exactly like any other stop.
// R3 - the limit lasts 256 minus the preset, counted at half the clock rate.
// R4 - an enabled external falling edge or a software write of 1 starts counting from the preload.
// R5 - software clear, second comparator fall, counter overflow or width limit stop the count.
// R6 - restart enable and comparator stop enable choose which sources may start and stop.
// R7 - with restart enable clear only software may start; the bit resets to zero.
// R8 - with reload enable set a first comparator fall switches reload to the second preload.
// R9 - a fixed option chooses a clock-synchronised start or a start on the trigger edge.
// R10 - a fixed option blocks triggers during the non-retrigger interval after a stop.
// R11 - software sets both preload bytes and their ninth bits before triggering.
// R12 - reload source bit picks the first preload at 0, the second at 1, resets to 0.
// R13 - edge count bit picks single or double external falling edge, resets to single.
// R14 - every stop reloads the counter, clears the software trigger bit and idles the output.
// R15 - a second comparator fall stops the pulse only while comparator stop enable is 1.
// R16 - triggers while running are ignored and leave the count alone.
// R17 - a second or third comparator fall clears restart enable, running or not.
`timescale 1ns/1ps
module ospc_top
	import ospc_pkg::*;
#(
	parameter bit SYNC_START = 1'b1,
	parameter bit NONRETRIG_EN = 1'b0,
	parameter bit ACTIVE_HIGH = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire ospc_bus_req_t bus_req,
	output logic [7:0] rd_data,
	input wire logic external_trigger_input,
	input wire logic debounced_cmp_one,
	input wire logic debounced_cmp_two,
	input wire logic debounced_cmp_three,
	input wire logic nonretrig_busy,
	output logic pulse_out,
	output logic stop_pulse
);

	// ==========================================================
	// helpers
	function automatic logic fell(input logic prev, input logic cur);
		return prev & ~cur;
	endfunction

	function automatic logic [8:0] pick_preload(input logic sel, input logic [8:0] a,
		input logic [8:0] b);
		return sel ? b : a;
	endfunction

	// ==========================================================
	// reset release
	logic rst_meta_r;
	logic rst_sync_n;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_n <= rst_meta_r;
		end
	end

	// ==========================================================
	// input synchronisers and edge history
	logic [3:0] pin_meta_r;
	logic [3:0] pin_sync_r;
	logic [3:0] pin_prev_r;
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pin_meta_r <= 4'hF;
			pin_sync_r <= 4'hF;
			pin_prev_r <= 4'hF;
		end else begin
			pin_meta_r <= {debounced_cmp_three, debounced_cmp_two, debounced_cmp_one,
				external_trigger_input};
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	wire ext_fall = fell(pin_prev_r[0], pin_sync_r[0]);
	wire c1_fall = fell(pin_prev_r[1], pin_sync_r[1]);
	wire c2_fall = fell(pin_prev_r[2], pin_sync_r[2]);
	wire c3_fall = fell(pin_prev_r[3], pin_sync_r[3]);

	// ==========================================================
	// state
	ospc_ctrl_t ctrl_r;
	ospc_ctrl_t ctrl_nxt;
	ospc_state_t state_r;
	ospc_state_t state_nxt;
	logic [7:0] pre_first_r;
	logic [7:0] pre_second_r;
	logic pre_first_hi_r;
	logic pre_second_hi_r;
	logic [7:0] wl_preset_r;
	logic [8:0] count_r;
	logic [8:0] count_nxt;
	logic [7:0] wl_r;
	logic [7:0] wl_nxt;
	logic div_r;
	logic edge_half_r;
	logic edge_half_nxt;
	logic pulse_out_r;
	logic stop_pulse_r;
	logic [7:0] rd_data_r;

	// ==========================================================
	// bus decode
	wire wr_ctrl = bus_req.wr_en && (bus_req.addr == OSPC_ADDR_CTRL);
	wire ospc_ctrl_t wr_fields = ospc_ctrl_t'(bus_req.wdata);
	wire [8:0] pre_first = {pre_first_hi_r, pre_first_r};
	wire [8:0] pre_second = {pre_second_hi_r, pre_second_r};
	wire [8:0] preload = pick_preload(ctrl_r.reload_source_select, pre_first, pre_second);
	wire idle = (state_r == ST_IDLE);
	wire running = (state_r == ST_RUN);

	// ==========================================================
	// start decode
	// R10 non-retrigger block
	wire blocked = NONRETRIG_EN && nonretrig_busy;
	// R4 software start
	wire soft_set = wr_ctrl && wr_fields.soft_trigger_bit && !ctrl_r.soft_trigger_bit;
	// R13 double edge needs the second fall
	wire ext_armed = !ctrl_r.edge_count_select || edge_half_r;
	// R6 R7 external start gated by restart enable
	wire ext_fire = ctrl_r.ext_restart_enable && ext_fall && ext_armed;
	// R16 triggers only count while idle
	wire start_evt = idle && !blocked && (soft_set || ext_fire);

	// ==========================================================
	// stop decode
	wire cnt_ovf = running && (count_r == OSPC_CNT_LAST);
	// R3 half-rate tick
	wire wl_tick = running && (div_r == OSPC_WL_DIV_LAST);
	// R2 width limit overflow
	wire wl_ovf = wl_tick && (wl_r == OSPC_WL_LAST);
	// R5 software clear
	wire soft_clr = wr_ctrl && !wr_fields.soft_trigger_bit && !idle;
	// R6 R15 comparator stop gate
	wire cmp_stop = ctrl_r.comparator_stop_enable && c2_fall && !idle;
	// R5 stop sources
	wire stop_evt = cnt_ovf || wl_ovf || soft_clr || cmp_stop;

	// ==========================================================
	// sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				// R9 synchronised start adds one clock
				if (start_evt) begin
					state_nxt = SYNC_START ? ST_SYNC : ST_RUN;
				end
			end
			ST_SYNC: begin
				state_nxt = stop_evt ? ST_IDLE : ST_RUN;
			end
			default: begin
				if (stop_evt) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	always_comb begin
		count_nxt = count_r;
		// R12 R14 reload from the selected preload
		if (start_evt || stop_evt) begin
			count_nxt = preload;
		end else if (running) begin
			count_nxt = count_r + 9'h001;
		end
	end

	// R1 limit timer runs only with the pulse
	always_comb begin
		wl_nxt = wl_r;
		if (start_evt) begin
			wl_nxt = wl_preset_r;
		end else if (wl_tick && !stop_evt) begin
			wl_nxt = wl_r + 8'h01;
		end
	end

	always_comb begin
		edge_half_nxt = edge_half_r;
		if (!idle || start_evt || !ctrl_r.edge_count_select) begin
			edge_half_nxt = 1'b0;
		end else if (ext_fall && ctrl_r.ext_restart_enable) begin
			edge_half_nxt = !edge_half_r;
		end
	end

	// ==========================================================
	// control register
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt = wr_fields;
			ctrl_nxt.soft_trigger_bit = ctrl_r.soft_trigger_bit;
		end
		ctrl_nxt.rsvd = 2'h0;
		// R8 comparator switches reload source, winning over a write
		if (c1_fall && ctrl_r.comparator_reload_enable) begin
			ctrl_nxt.reload_source_select = 1'b1;
		end
		// R17 comparator fall drops restart enable
		if (c2_fall || c3_fall) begin
			ctrl_nxt.ext_restart_enable = 1'b0;
		end
		// R14 stop clears the software trigger bit
		if (stop_evt) begin
			ctrl_nxt.soft_trigger_bit = 1'b0;
		end else if (start_evt) begin
			ctrl_nxt.soft_trigger_bit = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_r <= ospc_ctrl_t'(OSPC_CTRL_RESET);
			state_r <= ST_IDLE;
			count_r <= 9'h000;
			wl_r <= OSPC_BYTE_ZERO;
			div_r <= 1'b0;
			edge_half_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			state_r <= state_nxt;
			count_r <= count_nxt;
			wl_r <= wl_nxt;
			div_r <= running ? !div_r : 1'b0;
			edge_half_r <= edge_half_nxt;
		end
	end

	// preload and limit registers have no documented reset; zero is used
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pre_first_r <= OSPC_BYTE_ZERO;
			pre_second_r <= OSPC_BYTE_ZERO;
			pre_first_hi_r <= 1'b0;
			pre_second_hi_r <= 1'b0;
			wl_preset_r <= OSPC_BYTE_ZERO;
		end else if (bus_req.wr_en) begin
			if (bus_req.addr == OSPC_ADDR_PRE_FIRST) begin
				pre_first_r <= bus_req.wdata;
			end else if (bus_req.addr == OSPC_ADDR_PRE_SECOND) begin
				pre_second_r <= bus_req.wdata;
			end else if (bus_req.addr == OSPC_ADDR_PRE_NINTH) begin
				pre_first_hi_r <= bus_req.wdata[OSPC_NINTH_FIRST_BIT];
				pre_second_hi_r <= bus_req.wdata[OSPC_NINTH_SECOND_BIT];
			end else if (bus_req.addr == OSPC_ADDR_WL_PRESET) begin
				wl_preset_r <= bus_req.wdata;
			end
		end
	end

	// ==========================================================
	// read mux: unmapped bits read zero
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = OSPC_BYTE_ZERO;
		if (bus_req.addr == OSPC_ADDR_CTRL) begin
			rd_mux = ctrl_r;
		end else if (bus_req.addr == OSPC_ADDR_PRE_FIRST) begin
			rd_mux = pre_first_r;
		end else if (bus_req.addr == OSPC_ADDR_PRE_SECOND) begin
			rd_mux = pre_second_r;
		end else if (bus_req.addr == OSPC_ADDR_PRE_NINTH) begin
			rd_mux[OSPC_NINTH_FIRST_BIT] = pre_first_hi_r;
			rd_mux[OSPC_NINTH_SECOND_BIT] = pre_second_hi_r;
		end else if (bus_req.addr == OSPC_ADDR_WL_PRESET) begin
			rd_mux = wl_preset_r;
		end else if (bus_req.addr == OSPC_ADDR_STATUS) begin
			rd_mux[OSPC_STAT_ACTIVE_BIT] = !idle;
			rd_mux[OSPC_STAT_BLOCK_BIT] = blocked;
		end else if (bus_req.addr == OSPC_ADDR_CNT_LOW) begin
			rd_mux = count_r[7:0];
		end else begin
			rd_mux[0] = count_r[8];
		end
	end

	// ==========================================================
	// outputs from flops
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rd_data_r <= OSPC_BYTE_ZERO;
			pulse_out_r <= !ACTIVE_HIGH;
			stop_pulse_r <= 1'b0;
		end else begin
			rd_data_r <= bus_req.rd_en ? rd_mux : OSPC_BYTE_ZERO;
			pulse_out_r <= (state_nxt == ST_RUN) ~^ ACTIVE_HIGH;
			stop_pulse_r <= stop_evt;
		end
	end

	assign rd_data = rd_data_r;
	assign pulse_out = pulse_out_r;
	assign stop_pulse = stop_pulse_r;

	// ==========================================================
	// checks
	property p_cnt_ovf_stop; // R5
		@(posedge clk) disable iff (!rst_sync_n)
		(running && count_r == OSPC_CNT_LAST) |=> (state_r == ST_IDLE) && (count_r == $past(preload));
	endproperty
	a_cnt_ovf_stop: assert property (p_cnt_ovf_stop) else $error("overflow did not stop and reload");
	property p_wl_stop; // R2
		@(posedge clk) disable iff (!rst_sync_n)
		(running && div_r && wl_r == OSPC_WL_LAST) |=> state_r == ST_IDLE;
	endproperty
	a_wl_stop: assert property (p_wl_stop) else $error("width limit did not stop pulse");
	property p_wl_rate; // R3
		@(posedge clk) disable iff (!rst_sync_n)
		(running && !stop_evt && !start_evt) |=> (wl_r == $past(wl_r) + 8'(div_r ^ 1'b1) - 8'h00)
			|| ($past(div_r) && wl_r == $past(wl_r) + 8'h01);
	endproperty
	a_wl_rate: assert property (p_wl_rate) else $error("limit timer advanced at wrong rate");
	property p_soft_start; // R4
		@(posedge clk) disable iff (!rst_sync_n)
		(idle && soft_set && !blocked) |=> !idle && ctrl_r.soft_trigger_bit ##1 (running || $past(stop_evt));
	endproperty
	a_soft_start: assert property (p_soft_start) else $error("software start not taken");
	property p_ext_gate; // R7
		@(posedge clk) disable iff (!rst_sync_n)
		(idle && !ctrl_r.ext_restart_enable && !soft_set) |=> state_r == ST_IDLE;
	endproperty
	a_ext_gate: assert property (p_ext_gate) else $error("start without restart enable");
	property p_reload_sel; // R8
		@(posedge clk) disable iff (!rst_sync_n)
		(c1_fall && ctrl_r.comparator_reload_enable) |=> ctrl_r.reload_source_select;
	endproperty
	a_reload_sel: assert property (p_reload_sel) else $error("reload source not switched");
	property p_stop_effects; // R14
		@(posedge clk) disable iff (!rst_sync_n)
		(!idle && stop_evt) |=> !ctrl_r.soft_trigger_bit && (pulse_out == !ACTIVE_HIGH) && idle;
	endproperty
	a_stop_effects: assert property (p_stop_effects) else $error("stop left pulse active");
	property p_cmp_gate; // R15
		@(posedge clk) disable iff (!rst_sync_n)
		(running && c2_fall && !ctrl_r.comparator_stop_enable && !cnt_ovf && !wl_ovf && !soft_clr)
			|=> running;
	endproperty
	a_cmp_gate: assert property (p_cmp_gate) else $error("comparator stopped while disabled");

	property p_run_ignore; // R16
		@(posedge clk) disable iff (!rst_sync_n)
		(running && !stop_evt) |=> count_r == $past(count_r) + 9'h001;
	endproperty
	a_run_ignore: assert property (p_run_ignore) else $error("count disturbed while running");

	property p_restart_clr; // R17
		@(posedge clk) disable iff (!rst_sync_n)
		(c2_fall || c3_fall) |=> !ctrl_r.ext_restart_enable;
	endproperty
	a_restart_clr: assert property (p_restart_clr) else $error("restart enable not cleared");

endmodule // ospc_top

// ---- tb/ospc_pin_model.sv ----
// ospc_pin_model: trigger pin and debounced comparator outputs around the pulse control
// assumes the bench calls fall() from its main sequence; lines idle high between edges
`timescale 1ns/1ps
module ospc_pin_model (
	input wire logic clk,
	output logic external_trigger_input,
	output logic debounced_cmp_one,
	output logic debounced_cmp_two,
	output logic debounced_cmp_three,
	output logic nonretrig_busy
);
	// ==========================================================
	// line levels: 0 ext pin, 1..3 comparators
	logic [3:0] lines_r = 4'hF;

	assign external_trigger_input = lines_r[0];
	assign debounced_cmp_one = lines_r[1];
	assign debounced_cmp_two = lines_r[2];
	assign debounced_cmp_three = lines_r[3];
	// level of the interval timer that owns the retrigger block
	logic busy_r = 1'b0;
	assign nonretrig_busy = busy_r;

	// ==========================================================
	// one falling edge, held long enough to pass the synchronisers
	task automatic fall(input int which);
		@(posedge clk);
		lines_r[which] <= 1'b0;
		repeat (4) @(posedge clk);
		lines_r[which] <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	// interval timer level, changed just after a clock edge
	task automatic hold_busy(input logic v);
		@(posedge clk);
		busy_r <= v;
	endtask
endmodule // ospc_pin_model

// ---- tb/test_one_shot_pulse_control.sv ----
// test_one_shot_pulse_control: register and pulse tests of the one-shot pulse control
// assumes synchronised start and active high by default; the retrigger block is built in
`timescale 1ns/1ps
module test_one_shot_pulse_control;
	import ospc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	ospc_bus_req_t bus_req = '0;
	logic [7:0] rd_data;
	logic ext_in, cmp_one, cmp_two, cmp_three, busy;
	logic pulse_out, stop_pulse;
	int fails = 0;
	int cmp_count = 0;
	int stops = 0;
	int n;

	always #12.5 clk = ~clk;

	ospc_pin_model i_ospc_pin_model (.clk(clk), .external_trigger_input(ext_in),
		.debounced_cmp_one(cmp_one), .debounced_cmp_two(cmp_two),
		.debounced_cmp_three(cmp_three), .nonretrig_busy(busy));

	ospc_top #(.NONRETRIG_EN(1'b1)) i_ospc_top (
		.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
		.external_trigger_input(ext_in), .debounced_cmp_one(cmp_one),
		.debounced_cmp_two(cmp_two), .debounced_cmp_three(cmp_three),
		.nonretrig_busy(busy), .pulse_out(pulse_out), .stop_pulse(stop_pulse));

	always @(posedge clk) begin
		if (stop_pulse === 1'b1) begin
			stops++;
		end
	end

	// ==========================================================
	// bus and check tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus_req <= '0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string msg);
		@(posedge clk);
		bus_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		bus_req <= '0;
		@(negedge clk);
		chk({24'h0, rd_data}, {24'h0, exp}, msg);
	endtask

	// counts active cycles of the next pulse; 0 if none starts within 20 cycles
	task automatic measure(output int len);
		int w;
		len = 0;
		w = 0;
		while (pulse_out !== 1'b1 && w < 20) begin
			@(negedge clk);
			w++;
		end
		while (pulse_out === 1'b1 && len < 600) begin
			@(negedge clk);
			len++;
		end
	endtask

	task automatic ext_shot(output int len);
		fork
			i_ospc_pin_model.fall(0);
			measure(len);
		join
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		print_verdict();
	end

	// ==========================================================
	// tests
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int a = 0; a < 5; a++) begin
			rd(3'(a), 8'h00, "reset value");
		end
		wr(OSPC_ADDR_STATUS, 8'hFF);
		rd(OSPC_ADDR_STATUS, 8'h00, "status write ignored");
		wr(OSPC_ADDR_CTRL, 8'h7F);
		rd(OSPC_ADDR_CTRL, 8'h73, "control readback");
		$display("test registers done");

		// preload 0x1F0 gives 16 active cycles, set up before triggering
		wr(OSPC_ADDR_CTRL, 8'h00);
		wr(OSPC_ADDR_PRE_NINTH, 8'h01);
		wr(OSPC_ADDR_PRE_FIRST, 8'hF0);
		wr(OSPC_ADDR_CTRL, 8'h80);
		@(negedge clk);
		chk(pulse_out, 1'b0, "start waits one clock");
		measure(n);
		chk(n, 16, "soft pulse width");
		rd(OSPC_ADDR_CTRL, 8'h00, "trigger bit cleared");
		rd(OSPC_ADDR_CNT_LOW, 8'hF0, "count reloaded low");
		rd(OSPC_ADDR_CNT_HIGH, 8'h01, "count reloaded high");
		wr(OSPC_ADDR_CTRL, 8'hC0);
		fork
			measure(n);
			begin
				repeat (3) @(posedge clk);
				i_ospc_pin_model.fall(0);
				wr(OSPC_ADDR_CTRL, 8'hC0);
			end
		join
		chk(n, 16, "retrigger ignored");
		$display("test soft pulse done");

		// full span 512, limit (256-0xFB)*2 = 10 cycles
		wr(OSPC_ADDR_CTRL, 8'h00);
		wr(OSPC_ADDR_PRE_NINTH, 8'h00);
		wr(OSPC_ADDR_PRE_FIRST, 8'h00);
		wr(OSPC_ADDR_WL_PRESET, 8'hFB);
		wr(OSPC_ADDR_CTRL, 8'h80);
		measure(n);
		chk(n, 10, "width limit");
		rd(OSPC_ADDR_CTRL, 8'h00, "limit clears trigger bit");
		wr(OSPC_ADDR_WL_PRESET, 8'h00);
		wr(OSPC_ADDR_CTRL, 8'h80);
		fork
			measure(n);
			begin
				repeat (3) @(posedge clk);
				rd(OSPC_ADDR_STATUS, 8'h01, "status active");
				wr(OSPC_ADDR_CTRL, 8'h00);
			end
		join
		chk(n > 0 && n < 16, 1, "software stop");
		$display("test limit and stop done");

		// comparator stop, enabled then disabled, with preload 0x1F0
		wr(OSPC_ADDR_PRE_NINTH, 8'h01);
		wr(OSPC_ADDR_PRE_FIRST, 8'hF0);
		for (int e = 1; e >= 0; e--) begin
			wr(OSPC_ADDR_CTRL, e ? 8'hA0 : 8'h80);
			fork
				measure(n);
				begin
					repeat (2) @(posedge clk);
					i_ospc_pin_model.fall(2);
				end
			join
			chk(e ? (n > 0 && n < 16) : (n == 16), 1, "comparator stop");
		end
		for (int c = 2; c < 4; c++) begin
			wr(OSPC_ADDR_CTRL, 8'h40);
			i_ospc_pin_model.fall(c);
			rd(OSPC_ADDR_CTRL, 8'h00, "restart enable cleared");
		end
		$display("test comparators done");

		// external trigger: disabled, enabled, then double edge
		ext_shot(n);
		chk(n, 0, "ext ignored when disabled");
		wr(OSPC_ADDR_CTRL, 8'h40);
		ext_shot(n);
		chk(n, 16, "ext start");
		wr(OSPC_ADDR_CTRL, 8'h42);
		ext_shot(n);
		chk(n, 0, "one edge in double mode");
		ext_shot(n);
		chk(n, 16, "second edge starts");
		$display("test external trigger done");

		// reload source: both ninth bits set, second preload 0x1F8
		wr(OSPC_ADDR_PRE_NINTH, 8'h11);
		wr(OSPC_ADDR_PRE_SECOND, 8'hF8);
		wr(OSPC_ADDR_CTRL, 8'h00);
		i_ospc_pin_model.fall(1);
		rd(OSPC_ADDR_CTRL, 8'h00, "reload switch disabled");
		wr(OSPC_ADDR_CTRL, 8'h01);
		i_ospc_pin_model.fall(1);
		rd(OSPC_ADDR_CTRL, 8'h11, "reload switched");
		wr(OSPC_ADDR_CTRL, 8'h91);
		measure(n);
		chk(n, 8, "second preload width");
		repeat (4) @(posedge clk);
		chk(stops, 9, "stop pulses");
		$display("test reload source done");

		// retrigger block: a busy interval timer refuses starts
		i_ospc_pin_model.hold_busy(1'b1);
		wr(OSPC_ADDR_CTRL, 8'h80);
		measure(n);
		chk(n, 0, "start blocked");
		rd(OSPC_ADDR_STATUS, 8'h02, "status blocked");
		rd(OSPC_ADDR_CTRL, 8'h00, "blocked start leaves bit clear");
		i_ospc_pin_model.hold_busy(1'b0);
		$display("test retrigger block done");
		print_verdict();
	end
endmodule // test_one_shot_pulse_control
